// ===== rtl/sar_adc_control.v
// Control logic of a 10-bit successive-approximation converter
// Behaviour
// (RULE1) Ten-bit successive approximation result into result pair
// (RULE2) Result registers ignore software writes
// (RULE3) Channel field routes input to sample-and-hold
// (RULE4) Software waits acquisition time after channel change
// (RULE5) Reference bit picks supply or pin; ground negative
// (RULE6) Clock select maps to six dividers or oscillator
// (RULE7) One period per bit; eleven periods per conversion
// (RULE8) Divided clocks follow system clock frequency
// (RULE9) Oscillator above 1 MHz only for sleep
// (RULE10) Done flag set after every conversion
// (RULE11) Done flag holds until software clears it
// (RULE12) Interrupt when flag and enable both set
// (RULE13) Conversion interrupt during sleep wakes device
// (RULE14) Justify bit picks left or right format
// (RULE15) Runs only when enabled; go bit starts
// (RULE16) Completion clears go, sets flag, loads result
// (RULE17) Clearing go aborts, keeps previous result
// (RULE18) After abort wait two periods, then acquire
// (RULE19) Right: high holds two bits; left: eight
// (RULE20) Go and done synchronised with oscillator domain
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_control_consts.vh"
module sar_adc_control (
  input wire i_clk,
  input wire i_nrst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [4:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire o_wb_ack,
  input wire i_sleep,
  input wire i_frc_clk,
  input wire i_cmp,
  output wire [2:0] o_chan_sel,
  output wire o_vref_ext,
  output wire [3:0] o_analog_pins,
  output wire o_sample,
  output wire [9:0] o_trial,
  output wire o_irq,
  output wire o_wake
);

  // Sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_ABORT = 2'b10;

  // Software-visible registers
  reg [7:0] conv_ctrl_reg; // Justify, reference, channel, go, enable
  reg [7:0] ana_sel_reg; // Clock select and analog pins
  reg [7:0] int_ctrl_reg; // Global and peripheral enables
  reg [7:0] pie_reg; // Done interrupt enable
  reg [7:0] pir_reg; // Done flag
  reg [9:0] result_reg; // Last complete result
  // Bus answer
  reg [31:0] rdat_reg;
  reg ack_reg;
  // Sequencer
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] tad_cnt_reg; // Periods spent in current state
  reg [9:0] sar_reg; // Trial code
  reg [9:0] bit_reg; // Bit under test, one-hot
  // Conversion-clock generation
  reg [5:0] div_cnt_reg;
  reg [2:0] frc_sync_reg; // Oscillator synchroniser
  reg frc_lvl_reg; // Filtered oscillator level
  // Registered outputs
  reg sample_reg;
  reg irq_reg;
  reg wake_reg;

  // Bus request decode
  // Taken once; the ack cycle masks a held request
  wire req = i_wb_cyc & i_wb_stb & ~ack_reg;
  // Writes need the low byte lane
  wire wr = req & i_wb_we & i_wb_sel[0];
  // Word address; byte bits ignored
  wire [4:0] adr = {i_wb_adr[4:2], 2'b00};
  wire wr_cc = wr & (adr == `OFS_CONV_CTRL);
  wire wr_pir = wr & (adr == `OFS_PIR);

  // Field views
  wire mod_on = conv_ctrl_reg[`CC_ON];
  wire go = conv_ctrl_reg[`CC_GO];
  wire [2:0] clk_sel = ana_sel_reg[`AS_CLK_HI:`AS_CLK_LO];
  wire use_frc = (clk_sel[1:0] == 2'b11);
  // Write data seen by the control register
  wire go_wr_val = i_wb_dat[`CC_GO];
  wire on_wr_val = i_wb_dat[`CC_ON];

  // Divider: log2 of ratio from select code
  // Code bits reordered so the ratio doubles per step
  wire [2:0] div_log = {clk_sel[1:0], clk_sel[2]} + 3'h1; // RULE6
  wire [5:0] div_mask = (6'h01 << div_log) - 6'h01;

  // Oscillator rising edge once stages two and three agree high
  wire frc_rise = frc_sync_reg[1] & frc_sync_reg[2] & ~frc_lvl_reg;
  // Divided tick once all masked counter bits are set
  wire div_tick = ((div_cnt_reg & div_mask) == div_mask);
  // Period tick from the selected source
  wire tick = use_frc ? frc_rise : div_tick; // RULE6

  // Sleep stops divided clocks, so conversion cannot continue
  // Oscillator keeps running in sleep
  wire sleep_kill = i_sleep & ~use_frc;

  // Start, abort and finish events
  // Start only from idle with module on
  wire start = (state_reg == ST_IDLE) & mod_on & go & ~sleep_kill; // RULE15
  // Software clearing go cuts a conversion
  wire sw_abort = wr_cc & ~go_wr_val; // RULE17
  // Turning the module off also cuts it
  wire off_abort = wr_cc & ~on_wr_val;
  // Any cut while converting
  wire abort = (state_reg == ST_CONV) & (sw_abort | off_abort | sleep_kill);
  // Eleventh tick ends a clean conversion
  wire done = (state_reg == ST_CONV) & tick & (tad_cnt_reg == `CONV_TADS - 4'h1) & ~abort; // RULE7

  // Final result, last bit resolved from comparator
  wire [9:0] final_res = i_cmp ? sar_reg : (sar_reg & ~bit_reg);

  // Justified views of result
  wire justify_right = conv_ctrl_reg[`CC_JUSTIFY]; // RULE14
  wire [7:0] res_high = justify_right ? {6'h00, result_reg[9:8]} : result_reg[9:2]; // RULE19
  wire [7:0] res_low = justify_right ? result_reg[7:0] : {result_reg[1:0], 6'h00}; // RULE19

  // Read multiplexer, unmapped words read zero
  reg [7:0] rmux;
  always @* begin
    case (adr)
      `OFS_CONV_CTRL: rmux = conv_ctrl_reg;
      `OFS_ANA_SEL: rmux = ana_sel_reg;
      `OFS_INT_CTRL: rmux = int_ctrl_reg;
      `OFS_PIE: rmux = pie_reg;
      `OFS_PIR: rmux = pir_reg;
      // Result pair in the chosen format
      `OFS_RES_HIGH: rmux = res_high;
      `OFS_RES_LOW: rmux = res_low;
      default: rmux = 8'h00;
    endcase
  end

  // Bus answer: ack one cycle after request, dropped next cycle
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      // Ack for exactly one cycle per request
      ack_reg <= req;
      // Read data held until the next request
      if (req) begin
        rdat_reg <= {24'h00_0000, rmux};
      end
    end
  end

  // Plain configuration registers; result pair has no write path
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      ana_sel_reg <= `RST_ANA_SEL;
      int_ctrl_reg <= `RST_INT_CTRL;
      pie_reg <= `RST_PIE;
    end else begin
      // Analog select and clock
      if (wr & (adr == `OFS_ANA_SEL)) begin
        ana_sel_reg <= i_wb_dat[7:0] & `MASK_ANA_SEL;
      end
      // Interrupt control
      if (wr & (adr == `OFS_INT_CTRL)) begin
        int_ctrl_reg <= i_wb_dat[7:0] & `MASK_INT_CTRL;
      end
      // Interrupt enable
      if (wr & (adr == `OFS_PIE)) begin
        pie_reg <= i_wb_dat[7:0] & `MASK_PI;
      end
    end
  end

  // Converter control: hardware clears go on finish or abort
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      conv_ctrl_reg <= `RST_CONV_CTRL;
    end else if (wr_cc) begin
      // Software write; finish in same cycle still clears go
      conv_ctrl_reg <= i_wb_dat[7:0] & `MASK_CONV_CTRL;
      if (done) begin
        conv_ctrl_reg[`CC_GO] <= 1'b0; // RULE16
      end
    end else if (done | abort) begin
      // Hardware clear after finish or abort
      conv_ctrl_reg[`CC_GO] <= 1'b0; // RULE16
    end else if (go & ~mod_on) begin
      // Go has no meaning while disabled
      conv_ctrl_reg[`CC_GO] <= 1'b0; // RULE15
    end
  end

  // Done flag: set wins over software clear
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      pir_reg <= `RST_PIR;
    end else begin
      // Only software changes the flag otherwise
      if (wr_pir) begin
        pir_reg <= i_wb_dat[7:0] & `MASK_PI; // RULE11
      end
      // Finish sets the flag whatever the enable
      if (done) begin
        pir_reg[`PI_CONV] <= 1'b1; // RULE10
      end
    end
  end

  // Result pair loads only on a complete conversion
  // No bus write path reaches these bits
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      result_reg <= 10'h000;
    end else if (done) begin
      result_reg <= final_res; // RULE1 RULE2 RULE16 RULE17
    end
  end

  // Divider off the system clock, restarted on start and abort
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      div_cnt_reg <= 6'h00;
    end else if (start | abort) begin
      // Whole first period for sampling and for the abort wait
      div_cnt_reg <= 6'h00; // RULE7 RULE18
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01; // RULE8
    end
  end

  // Oscillator synchroniser and edge filter
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      frc_sync_reg <= 3'h0;
      frc_lvl_reg <= 1'b0;
    end else begin
      // Three-stage shift of the asynchronous oscillator
      frc_sync_reg <= {frc_sync_reg[1:0], i_frc_clk}; // RULE20
      // Level changes only when stages two and three agree
      if (frc_sync_reg[1] == frc_sync_reg[2]) begin
        frc_lvl_reg <= frc_sync_reg[2];
      end
    end
  end

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Wait for go with module on
        if (start) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        // Abort has priority over finish
        if (abort) begin
          state_next = ST_ABORT; // RULE17
        end else if (done) begin
          state_next = ST_IDLE;
        end
      end
      ST_ABORT: begin
        // Two periods before acquisition resumes
        if (tick & (tad_cnt_reg == `ABORT_TADS - 4'h1)) begin
          state_next = ST_IDLE; // RULE18
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers and approximation
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      tad_cnt_reg <= 4'h0;
      sar_reg <= 10'h000;
      bit_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      // Period counter restarts on every state change
      if (state_reg != state_next) begin
        tad_cnt_reg <= 4'h0;
      end else if (tick) begin
        tad_cnt_reg <= tad_cnt_reg + 4'h1; // RULE7
      end
      if (start) begin
        // First period holds sample; top bit tried first
        sar_reg <= 10'h200;
        bit_reg <= 10'h200;
      end else if ((state_reg == ST_CONV) & tick & (tad_cnt_reg != 4'h0)) begin
        // Keep or drop bit on comparator, try next one
        sar_reg <= final_res | (bit_reg >> 1); // RULE1
        bit_reg <= bit_reg >> 1;
      end
    end
  end

  // Analog side and interrupt outputs
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      sample_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      // Track input only when enabled and not converting
      sample_reg <= mod_on & (state_next == ST_IDLE) & ~sleep_kill; // RULE18 RULE4
      // Interrupt level from flag and enable
      irq_reg <= pir_reg[`PI_CONV] & pie_reg[`PI_CONV]; // RULE12
      // Wake only while asleep
      wake_reg <= pir_reg[`PI_CONV] & pie_reg[`PI_CONV] & i_sleep; // RULE13
    end
  end

  // Output drive
  // Bus side
  assign o_wb_dat = rdat_reg;
  assign o_wb_ack = ack_reg;
  // Analog side
  assign o_chan_sel = conv_ctrl_reg[`CC_CHS_HI:`CC_CHS_LO]; // RULE3
  assign o_vref_ext = conv_ctrl_reg[`CC_VREF]; // RULE5
  assign o_analog_pins = ana_sel_reg[`AS_PIN_HI:`AS_PIN_LO];
  assign o_sample = sample_reg;
  assign o_trial = sar_reg;
  // Interrupt side
  assign o_irq = irq_reg;
  assign o_wake = wake_reg;

endmodule
`default_nettype wire

// ===== rtl/sar_adc_control_consts.vh
// Constants for the successive-approximation converter control block
`ifndef SAR_ADC_CONTROL_CONSTS_VH
`define SAR_ADC_CONTROL_CONSTS_VH
// Register byte offsets
`define OFS_CONV_CTRL 5'h00
`define OFS_ANA_SEL 5'h04
`define OFS_INT_CTRL 5'h08
`define OFS_PIE 5'h0c
`define OFS_PIR 5'h10
`define OFS_RES_HIGH 5'h14
`define OFS_RES_LOW 5'h18
// Reset values
`define RST_CONV_CTRL 8'h00
`define RST_ANA_SEL 8'h0f
`define RST_INT_CTRL 8'h00
`define RST_PIE 8'h00
`define RST_PIR 8'h00
// Converter control fields
`define CC_JUSTIFY 7
`define CC_VREF 6
`define CC_CHS_HI 4
`define CC_CHS_LO 2
`define CC_GO 1
`define CC_ON 0
// Analog select and clock fields
`define AS_CLK_HI 6
`define AS_CLK_LO 4
`define AS_PIN_HI 3
`define AS_PIN_LO 0
// Interrupt control fields
`define IC_GIE 7
`define IC_PERIPHERAL_IRQ_ENABLE 6
// Flag and enable position in the peripheral registers
`define PI_CONV 6
// Write masks of implemented bits
`define MASK_CONV_CTRL 8'hdf
`define MASK_ANA_SEL 8'h7f
`define MASK_INT_CTRL 8'hc0
`define MASK_PI 8'h40
// Sequencing counts in conversion-clock periods, and result width in bits
`define CONV_TADS 4'hb
`define ABORT_TADS 4'h2
`define RES_BITS 10
`endif

// ===== tb/adc_core_model.sv
// Analog core model: input level and comparator
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  input wire logic [9:0] i_vin,
  input wire logic [2:0] i_chan,
  input wire logic i_vref_ext,
  input wire logic [9:0] i_trial,
  output logic o_cmp
);
  // Level seen by the comparator
  logic [9:0] lvl;
  // Scale by reference, XOR top three bits with channel, compare with trial code
  always_comb begin
    lvl = i_vref_ext ? {1'b0, i_vin[9:1]} : i_vin;
    lvl = lvl ^ {i_chan, 7'h00};
    o_cmp = lvl >= i_trial;
  end
endmodule
`default_nettype wire

// ===== tb/sar_adc_control_chk.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [4:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_sleep,
  input wire logic i_frc_clk,
  input wire logic i_cmp,
  input wire logic [2:0] o_chan_sel,
  input wire logic o_vref_ext,
  input wire logic [3:0] o_analog_pins,
  input wire logic o_sample,
  input wire logic [9:0] o_trial,
  input wire logic o_irq,
  input wire logic o_wake
);
  // Request taken, and a write that lands
  wire logic tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire logic wr = tk && i_wb_we && i_wb_sel[0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_ack_pulse: assert property (tk |=> o_wb_ack)
    else $error("ack missing");
  a_ack_drop: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  a_chan_route: assert property (
    wr && i_wb_adr[4:2] == 3'h0 |=> o_chan_sel == $past(i_wb_dat[4:2]))
    else $error("channel output wrong");
  a_vref_route: assert property (
    wr && i_wb_adr[4:2] == 3'h0 |=> o_vref_ext == $past(i_wb_dat[6]))
    else $error("reference output wrong");
  a_pins_route: assert property (
    wr && i_wb_adr[4:2] == 3'h1 |=> o_analog_pins == $past(i_wb_dat[3:0]))
    else $error("pin select wrong");
  a_rdat_top: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("read data top not zero");
  a_unmapped_zero: assert property (
    tk && !i_wb_we && i_wb_adr[4:2] == 3'h7 |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_wake_irq: assert property (1 |-> o_wake == (o_irq && $past(i_sleep)))
    else $error("wake does not follow irq");
  a_irq_hold: assert property ($fell(o_irq) |->
    $past(wr && (i_wb_adr[4:2] == 3'h3 || i_wb_adr[4:2] == 3'h4), 2))
    else $error("irq dropped without write");
  // Main scenarios reached
  c_irq: cover property ($rose(o_irq));
  c_wake: cover property ($rose(o_wake));
  c_start: cover property ($fell(o_sample));
endmodule
bind sar_adc_control sar_adc_control_chk u_chk (.*);
`default_nettype wire

// ===== tb/test_sar_adc_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_control;
  logic i_clk = 0, i_nrst = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic [4:0] i_wb_adr = 5'h00;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
  logic o_wb_ack, i_sleep = 0, i_frc_clk = 0, i_cmp, o_vref_ext, o_sample, o_irq, o_wake;
  logic [2:0] o_chan_sel;
  logic [3:0] o_analog_pins;
  logic [9:0] o_trial, vin = 10'h000;
  logic [7:0] rdat, exp_hi, exp_lo;
  int fail_count = 0, cmp_count = 0, tick = 0;
  // System clock and free oscillator
  always #4 i_clk = ~i_clk;
  always #23 i_frc_clk = ~i_frc_clk;
  always @(posedge i_clk) tick <= tick + 1;
  sar_adc_control DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sleep(i_sleep), .i_frc_clk(i_frc_clk),
    .i_cmp(i_cmp), .o_chan_sel(o_chan_sel), .o_vref_ext(o_vref_ext),
    .o_analog_pins(o_analog_pins), .o_sample(o_sample), .o_trial(o_trial), .o_irq(o_irq),
    .o_wake(o_wake));
  adc_core_model u_core (.i_vin(vin), .i_chan(o_chan_sel), .i_vref_ext(o_vref_ext),
    .i_trial(o_trial), .o_cmp(i_cmp));
  // Verdict and end of run
  task automatic test_done;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Compare and report
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic bus cycle; read data lands in rdat
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1;
    i_wb_stb <= 1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      ck("bus ack", 1, 0);
      test_done;
    end
    rdat = o_wb_dat[7:0];
    i_wb_cyc <= 0;
    i_wb_stb <= 0;
  endtask
  // One conversion, with result and flag checks
  task automatic conv(input logic [7:0] ctl, output int el);
    int t0, n;
    logic [9:0] r;
    bus(1, 5'h00, ctl | 8'h01);
    repeat (16) @(posedge i_clk);
    t0 = tick;
    bus(1, 5'h00, ctl | 8'h03);
    n = 0;
    do begin
      bus(0, 5'h00, 8'h00);
      n++;
    end while (rdat[1] !== 1'b0 && n < 500);
    el = tick - t0;
    if (n >= 500) begin
      ck("go clear", 0, 1);
      test_done;
    end
    r = ctl[6] ? {1'b0, vin[9:1]} : vin;
    r = r ^ {ctl[4:2], 7'h00};
    exp_hi = ctl[7] ? {6'h0, r[9:8]} : r[9:2];
    exp_lo = ctl[7] ? r[7:0] : {r[1:0], 6'h00};
    bus(0, 5'h14, 8'h00);
    ck("result high", exp_hi, rdat);
    bus(0, 5'h18, 8'h00);
    ck("result low", exp_lo, rdat);
    bus(0, 5'h10, 8'h00);
    ck("done flag", 8'h40, rdat);
  endtask
  // Reset values, write masks, read-only and unmapped places
  task automatic t_regs;
    logic [31:0] tv[7] = '{32'h0000fedc, 32'h040fff7f, 32'h0800ffc0, 32'h0c00ff40,
      32'h1400ff00, 32'h1800ff00, 32'h1c00ff00};
    for (int i = 0; i < 7; i++) begin
      bus(0, tv[i][28:24], 8'h00);
      ck("reset value", tv[i][23:16], rdat);
      bus(1, tv[i][28:24], tv[i][15:8]);
      bus(0, tv[i][28:24], 8'h00);
      ck("read back", tv[i][7:0], rdat);
    end
    bus(0, 5'h10, 8'h00);
    ck("flag reset", 8'h00, rdat);
    bus(1, 5'h08, 8'h00);
    bus(1, 5'h0c, 8'h00);
    $display("t_regs done");
  endtask
  // Every clock select code, with timing for the divided codes, channel and format
  task automatic t_clocks;
    int el, dv;
    for (int c = 0; c < 8; c++) begin
      dv = 2 << (c % 4 * 2 + c / 4);
      vin <= 10'h0a5 + 10'(c * 97);
      bus(1, 5'h04, {1'b0, 3'(c), 4'hf});
      // Oscillator codes only run asleep at this system clock
      i_sleep <= (c % 4 == 3);
      conv({c[0], c[2], 1'b0, 3'(c), 2'b00}, el);
      i_sleep <= 1'b0;
      if (c % 4 != 3) begin
        ck("time min", 1, el >= 10 * dv);
        ck("time max", 1, el <= 12 * dv + 16);
      end
      bus(1, 5'h10, 8'h00);
    end
    $display("t_clocks done");
  endtask
  // Interrupt raise, wake, mask, hold and clear
  task automatic t_irq;
    int el;
    bus(1, 5'h0c, 8'h40);
    bus(1, 5'h04, 8'h0f);
    vin <= 10'h3c1;
    conv(8'h80, el);
    ck("irq", 1, o_irq);
    i_sleep <= 1;
    repeat (3) @(posedge i_clk);
    ck("wake", 1, o_wake);
    i_sleep <= 0;
    bus(1, 5'h0c, 8'h00);
    repeat (3) @(posedge i_clk);
    ck("irq masked", 0, o_irq);
    repeat (20) @(posedge i_clk);
    bus(0, 5'h10, 8'h00);
    ck("flag held", 8'h40, rdat);
    bus(1, 5'h10, 8'h00);
    bus(0, 5'h10, 8'h00);
    ck("flag cleared", 8'h00, rdat);
    $display("t_irq done");
  endtask
  // Abort mid-conversion keeps the old result
  task automatic t_abort;
    bus(1, 5'h04, 8'h6f);
    vin <= 10'h011;
    bus(1, 5'h00, 8'h81);
    repeat (16) @(posedge i_clk);
    bus(1, 5'h00, 8'h83);
    repeat (100) @(posedge i_clk);
    bus(1, 5'h00, 8'h81);
    repeat (40) @(posedge i_clk);
    ck("abort wait", 0, o_sample);
    repeat (120) @(posedge i_clk);
    ck("acquire again", 1, o_sample);
    bus(0, 5'h10, 8'h00);
    ck("no flag", 8'h00, rdat);
    bus(0, 5'h14, 8'h00);
    ck("old high", exp_hi, rdat);
    bus(0, 5'h18, 8'h00);
    ck("old low", exp_lo, rdat);
    // Sleep on a divided clock cuts a running conversion
    bus(1, 5'h00, 8'h83);
    repeat (100) @(posedge i_clk);
    i_sleep <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sleep <= 1'b0;
    bus(0, 5'h00, 8'h00);
    ck("sleep abort go", 8'h81, rdat);
    repeat (160) @(posedge i_clk);
    ck("sleep acquire", 1, o_sample);
    bus(0, 5'h10, 8'h00);
    ck("sleep no flag", 8'h00, rdat);
    bus(0, 5'h14, 8'h00);
    ck("sleep old high", exp_hi, rdat);
    bus(0, 5'h18, 8'h00);
    ck("sleep old low", exp_lo, rdat);
    $display("t_abort done");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    i_nrst <= 1;
    t_regs;
    t_clocks;
    t_irq;
    t_abort;
    test_done;
  end
endmodule
`default_nettype wire
